// *** pkg/adc_mix_pkg.sv ***
// Constants, field layout and types of the record front-end register bank
// ****************************************************************************
// Functional notes
// ****************************************************************************
package adc_mix_pkg;

    // ************************************************************************
    // Register offsets
    // ************************************************************************
    localparam logic [7:0] ADDR_DET_DRV = 8'h0e;
    localparam logic [7:0] ADDR_LEFT_GAIN = 8'h0f;
    localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h10;
    localparam logic [7:0] ADDR_MIC3_LEFT = 8'h11;
    localparam logic [7:0] ADDR_MIC3_RIGHT = 8'h12;
    localparam logic [7:0] ADDR_FIRST_LINE_LEFT_IN = 8'h13;
    localparam logic [7:0] ADDR_SECOND_LINE_LEFT_IN = 8'h14;
    localparam logic [7:0] ADDR_FIRST_LINE_RIGHT_IN = 8'h15;

    // ************************************************************************
    // Bit positions and fields
    // ************************************************************************
    localparam int BIT_AC_COUPLED = 7;
    localparam int BIT_FULL_DIFF = 6;
    localparam int BIT_BUTTON = 5;
    localparam int BIT_HEADSET = 4;
    localparam int BIT_PSEUDO_DIFF = 3;
    localparam int BIT_MUTE = 7;
    localparam int BIT_SE_FD = 7;
    localparam int BIT_ADC_POWER = 2;
    localparam int BIT_WEAK_BIAS = 2;
    localparam int GAIN_MSB = 6;
    localparam int HI_LEVEL_MSB = 7;
    localparam int HI_LEVEL_LSB = 4;
    localparam int LO_LEVEL_MSB = 3;
    localparam int LINE_LEVEL_MSB = 6;
    localparam int LINE_LEVEL_LSB = 3;
    localparam int STEP_MSB = 1;
    localparam int LEFT_INPUTS = 5;
    localparam int RIGHT_INPUTS = 2;
    localparam int LINE_INPUTS = 3;

    // ************************************************************************
    // Write masks and reset values
    // ************************************************************************
    localparam logic [7:0] WMASK_DET_DRV = 8'hc8;
    localparam logic [7:0] WMASK_ALL = 8'hff;
    localparam logic [7:0] WMASK_SECOND_LINE_LEFT_IN = 8'hfc;
    localparam logic [7:0] WMASK_FIRST_LINE_RIGHT_IN = 8'hf8;
    localparam logic [7:0] RST_DET_DRV = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] RST_MIC3 = 8'hff;
    localparam logic [7:0] RST_LINE = 8'h78;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [2:0] READ_RESERVED_DET = 3'h0;

    // ************************************************************************
    // Codes
    // ************************************************************************
    localparam logic [6:0] GAIN_MAX = 7'h77;
    localparam logic [6:0] GAIN_STEP = 7'h01;
    localparam logic [3:0] LEVEL_OFF = 4'hf;
    localparam logic [3:0] LEVEL_MAX_VALID = 4'h8;

    typedef enum logic [1:0] {
        STEP_EVERY_FS = 2'b00,
        STEP_EVERY_2FS = 2'b01,
        STEP_OFF_A = 2'b10,
        STEP_OFF_B = 2'b11
    } step_mode_t;

endpackage : adc_mix_pkg

// *** core/pga_soft_step.sv ***
// Amplifier gain walker with optional soft stepping
`timescale 1ns/1ps
module pga_soft_step (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic fs_tick_i,
    input wire adc_mix_pkg::step_mode_t step_mode_i,
    input wire logic [6:0] target_i,
    output logic [6:0] gain_o
);
    import adc_mix_pkg::*;

    logic half_phase;
    logic [6:0] gain;
    logic [6:0] next_gain;

    wire soft_on = (step_mode_i == STEP_EVERY_FS) || (step_mode_i == STEP_EVERY_2FS);
    wire step_now = fs_tick_i && ((step_mode_i == STEP_EVERY_FS) || half_phase);
    wire gain_up = step_now && (gain < target_i);
    wire gain_down = step_now && (gain > target_i);

    // Instant change when off, else one half-dB per step period
    assign next_gain = !soft_on ? target_i :
                       gain_up ? 7'(gain + GAIN_STEP) :
                       gain_down ? 7'(gain - GAIN_STEP) : gain;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            gain <= 7'h00;
            half_phase <= 1'b0;
        end else begin
            gain <= next_gain;
            if (fs_tick_i) begin
                half_phase <= ~half_phase;
            end
        end
    end

    assign gain_o = gain;

    step_size_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        soft_on |=> ((gain - $past(gain)) == 7'h00 || (gain - $past(gain)) == 7'h01 ||
                     ($past(gain) - gain) == 7'h01))
        else $error("soft step moved gain by more than one code");

    instant_gain_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !soft_on |=> gain == $past(target_i))
        else $error("gain did not follow target with stepping off");

    hold_no_tick_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (soft_on && !fs_tick_i) |=> $stable(gain))
        else $error("gain moved without a sample tick");

endmodule : pga_soft_step

// *** core/adc_input_mix_pga_regs.sv ***
// Record front-end register bank: driver setup, detection flags, gains, mixer routing
`timescale 1ns/1ps
module adc_input_mix_pga_regs (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic button_press_i,
    input wire logic headset_present_i,
    input wire logic headset_det_en_i,
    input wire logic fs_tick_i,
    input wire adc_mix_pkg::step_mode_t right_step_mode_i,
    output logic ac_coupled_o,
    output logic full_diff_out_o,
    output logic pseudo_diff_out_o,
    output logic left_mute_o,
    output logic right_mute_o,
    output logic [6:0] left_gain_o,
    output logic [6:0] right_gain_o,
    output logic [4:0][3:0] left_mix_level_o,
    output logic [4:0] left_mix_connect_o,
    output logic [1:0][3:0] right_mix_level_o,
    output logic [1:0] right_mix_connect_o,
    output logic [2:0] single_or_diff_select_o,
    output logic left_adc_power_o,
    output logic left_weak_bias_o
);
    import adc_mix_pkg::*;

    // ************************************************************************
    // Storage
    // ************************************************************************
    logic [7:0] det_drv;
    logic [7:0] left_amp_gain;
    logic [7:0] right_amp_gain;
    logic [7:0] third_mic_to_left_mix;
    logic [7:0] third_mic_to_right_mix;
    logic [7:0] line1_left_to_left_mix;
    logic [7:0] line2_left_to_left_mix;
    logic [7:0] line1_right_to_left_mix;
    logic button_flag;
    logic headset_flag;
    logic [7:0] rdata;
    logic rvalid;
    logic [4:0] left_connect;
    logic [1:0] right_connect;

    // ************************************************************************
    // Pin synchronisers
    // ************************************************************************
    logic button_meta;
    logic button_sync;
    logic headset_meta;
    logic headset_sync;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            button_meta <= 1'b0;
            button_sync <= 1'b0;
            headset_meta <= 1'b0;
            headset_sync <= 1'b0;
        end else begin
            button_meta <= button_press_i;
            button_sync <= button_meta;
            headset_meta <= headset_present_i;
            headset_sync <= headset_meta;
        end
    end

    // ************************************************************************
    // Write decode
    // ************************************************************************
    wire wr_det_drv = reg_wr_i && (reg_addr_i == ADDR_DET_DRV);
    wire wr_left_gain = reg_wr_i && (reg_addr_i == ADDR_LEFT_GAIN);
    wire wr_right_gain = reg_wr_i && (reg_addr_i == ADDR_RIGHT_GAIN);
    wire wr_mic3_left = reg_wr_i && (reg_addr_i == ADDR_MIC3_LEFT);
    wire wr_mic3_right = reg_wr_i && (reg_addr_i == ADDR_MIC3_RIGHT);
    wire wr_first_line_left_in = reg_wr_i && (reg_addr_i == ADDR_FIRST_LINE_LEFT_IN);
    wire wr_second_line_left_in = reg_wr_i && (reg_addr_i == ADDR_SECOND_LINE_LEFT_IN);
    wire wr_first_line_right_in = reg_wr_i && (reg_addr_i == ADDR_FIRST_LINE_RIGHT_IN);
    wire rd_det_drv = reg_rd_i && (reg_addr_i == ADDR_DET_DRV);

    // Read-only and reserved positions masked off, never stored
    wire [7:0] next_det_drv = reg_wdata_i & WMASK_DET_DRV;
    wire [7:0] next_second_line_left_in = reg_wdata_i & WMASK_SECOND_LINE_LEFT_IN;
    wire [7:0] next_first_line_right_in = reg_wdata_i & WMASK_FIRST_LINE_RIGHT_IN;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            det_drv <= RST_DET_DRV;
            left_amp_gain <= RST_GAIN;
            right_amp_gain <= RST_GAIN;
            third_mic_to_left_mix <= RST_MIC3;
            third_mic_to_right_mix <= RST_MIC3;
            line1_left_to_left_mix <= RST_LINE;
            line2_left_to_left_mix <= RST_LINE;
            line1_right_to_left_mix <= RST_LINE;
        end else begin
            if (wr_det_drv) begin
                det_drv <= next_det_drv;
            end
            if (wr_left_gain) begin
                left_amp_gain <= reg_wdata_i & WMASK_ALL;
            end
            if (wr_right_gain) begin
                right_amp_gain <= reg_wdata_i & WMASK_ALL;
            end
            if (wr_mic3_left) begin
                third_mic_to_left_mix <= reg_wdata_i;
            end
            if (wr_mic3_right) begin
                third_mic_to_right_mix <= reg_wdata_i;
            end
            if (wr_first_line_left_in) begin
                line1_left_to_left_mix <= reg_wdata_i;
            end
            if (wr_second_line_left_in) begin
                line2_left_to_left_mix <= next_second_line_left_in;
            end
            if (wr_first_line_right_in) begin
                line1_right_to_left_mix <= next_first_line_right_in;
            end
        end
    end

    // ************************************************************************
    // Detection flags
    // ************************************************************************
    // A press in the read cycle survives: set beats clear
    wire button_event = button_sync && headset_det_en_i;
    wire next_button_flag = button_event || (button_flag && !rd_det_drv);
    wire next_headset_flag = headset_sync && headset_det_en_i;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            button_flag <= 1'b0;
            headset_flag <= 1'b0;
        end else begin
            button_flag <= next_button_flag;
            headset_flag <= next_headset_flag;
        end
    end

    // ************************************************************************
    // Read path
    // ************************************************************************
    logic [7:0] read_word;

    wire [7:0] det_drv_view = {det_drv[BIT_AC_COUPLED], det_drv[BIT_FULL_DIFF], button_flag,
                               headset_flag, det_drv[BIT_PSEUDO_DIFF], READ_RESERVED_DET};

    always_comb begin
        if (reg_addr_i == ADDR_DET_DRV) begin
            read_word = det_drv_view;
        end else if (reg_addr_i == ADDR_LEFT_GAIN) begin
            read_word = left_amp_gain;
        end else if (reg_addr_i == ADDR_RIGHT_GAIN) begin
            read_word = right_amp_gain;
        end else if (reg_addr_i == ADDR_MIC3_LEFT) begin
            read_word = third_mic_to_left_mix;
        end else if (reg_addr_i == ADDR_MIC3_RIGHT) begin
            read_word = third_mic_to_right_mix;
        end else if (reg_addr_i == ADDR_FIRST_LINE_LEFT_IN) begin
            read_word = line1_left_to_left_mix;
        end else if (reg_addr_i == ADDR_SECOND_LINE_LEFT_IN) begin
            read_word = line2_left_to_left_mix;
        end else if (reg_addr_i == ADDR_FIRST_LINE_RIGHT_IN) begin
            read_word = line1_right_to_left_mix;
        end else begin
            read_word = READ_UNMAPPED;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata <= READ_UNMAPPED;
            rvalid <= 1'b0;
        end else begin
            rvalid <= reg_rd_i;
            if (reg_rd_i) begin
                rdata <= read_word;
            end
        end
    end

    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;

    // ************************************************************************
    // Mixer routing
    // ************************************************************************
    wire [4:0][3:0] left_levels = {
        line1_right_to_left_mix[LINE_LEVEL_MSB:LINE_LEVEL_LSB],
        line2_left_to_left_mix[LINE_LEVEL_MSB:LINE_LEVEL_LSB],
        line1_left_to_left_mix[LINE_LEVEL_MSB:LINE_LEVEL_LSB],
        third_mic_to_left_mix[LO_LEVEL_MSB:0],
        third_mic_to_left_mix[HI_LEVEL_MSB:HI_LEVEL_LSB]
    };
    wire [1:0][3:0] right_levels = {
        third_mic_to_right_mix[LO_LEVEL_MSB:0],
        third_mic_to_right_mix[HI_LEVEL_MSB:HI_LEVEL_LSB]
    };

    // Reserved codes leave the input open rather than guessing an attenuation
    genvar gi;
    generate
        for (gi = 0; gi < LEFT_INPUTS; gi++) begin : g_left_connect
            always_ff @(posedge clk_sys_i or posedge reset_i) begin
                if (reset_i) begin
                    left_connect[gi] <= 1'b0;
                end else begin
                    left_connect[gi] <= (left_levels[gi] <= LEVEL_MAX_VALID);
                end
            end
        end
        for (gi = 0; gi < RIGHT_INPUTS; gi++) begin : g_right_connect
            always_ff @(posedge clk_sys_i or posedge reset_i) begin
                if (reset_i) begin
                    right_connect[gi] <= 1'b0;
                end else begin
                    right_connect[gi] <= (right_levels[gi] <= LEVEL_MAX_VALID);
                end
            end
        end
    endgenerate

    // Level codes pass on unchanged; the analog side reads 1.5 dB per code
    assign left_mix_level_o = left_levels;
    assign right_mix_level_o = right_levels;
    assign left_mix_connect_o = left_connect;
    assign right_mix_connect_o = right_connect;

    // ************************************************************************
    // Gain stepping
    // ************************************************************************
    wire [6:0] left_code = left_amp_gain[GAIN_MSB:0];
    wire [6:0] right_code = right_amp_gain[GAIN_MSB:0];
    wire [6:0] left_target = (left_code > GAIN_MAX) ? GAIN_MAX : left_code;
    wire [6:0] right_target = (right_code > GAIN_MAX) ? GAIN_MAX : right_code;
    wire step_mode_t left_step_mode = step_mode_t'(line1_left_to_left_mix[STEP_MSB:0]);

    pga_soft_step u_left_step (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .fs_tick_i(fs_tick_i),
        .step_mode_i(left_step_mode),
        .target_i(left_target),
        .gain_o(left_gain_o)
    );

    pga_soft_step u_right_step (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .fs_tick_i(fs_tick_i),
        .step_mode_i(right_step_mode_i),
        .target_i(right_target),
        .gain_o(right_gain_o)
    );

    // ************************************************************************
    // Control outputs
    // ************************************************************************
    assign ac_coupled_o = det_drv[BIT_AC_COUPLED];
    assign full_diff_out_o = det_drv[BIT_FULL_DIFF];
    assign pseudo_diff_out_o = det_drv[BIT_PSEUDO_DIFF];
    assign left_mute_o = left_amp_gain[BIT_MUTE];
    assign right_mute_o = right_amp_gain[BIT_MUTE];
    assign single_or_diff_select_o = {line1_right_to_left_mix[BIT_SE_FD],
                                      line2_left_to_left_mix[BIT_SE_FD],
                                      line1_left_to_left_mix[BIT_SE_FD]};
    assign left_adc_power_o = line1_left_to_left_mix[BIT_ADC_POWER];
    assign left_weak_bias_o = line2_left_to_left_mix[BIT_WEAK_BIAS];

    // ************************************************************************
    // Checks
    // ************************************************************************
    button_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (button_flag && !rd_det_drv) |=> button_flag)
        else $error("button flag dropped without a read");

    button_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (rd_det_drv && !button_event) |=> (!button_flag && reg_rdata_o[BIT_BUTTON] == $past(button_flag)))
        else $error("button flag not returned then cleared by read");

    headset_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !headset_det_en_i |=> !headset_flag)
        else $error("headset flag set with detection disabled");

    reserved_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rd_det_drv |=> reg_rvalid_o && reg_rdata_o[2:0] == READ_RESERVED_DET)
        else $error("reserved bits of detection register read nonzero");

    gain_sat_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (left_gain_o <= GAIN_MAX) && (right_gain_o <= GAIN_MAX))
        else $error("gain above saturation code");

    connect_map_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 left_connect[0] == ($past(third_mic_to_left_mix[HI_LEVEL_MSB:HI_LEVEL_LSB]) != LEVEL_OFF))
        else $error("third mic connect does not follow level code");

    power_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_first_line_left_in |=> left_adc_power_o == $past(reg_wdata_i[BIT_ADC_POWER]))
        else $error("left converter power did not take written value");

    coupling_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_det_drv |=> ac_coupled_o == $past(reg_wdata_i[BIT_AC_COUPLED]) && (det_drv & ~WMASK_DET_DRV) == 8'h00)
        else $error("coupling bit did not take written value");

    full_diff_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_det_drv |=> full_diff_out_o == $past(reg_wdata_i[BIT_FULL_DIFF]))
        else $error("full differential bit did not take written value");

    pseudo_diff_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_det_drv |=> pseudo_diff_out_o == $past(reg_wdata_i[BIT_PSEUDO_DIFF]))
        else $error("pseudodifferential bit did not take written value");

    left_mute_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_left_gain |=> left_mute_o == $past(reg_wdata_i[BIT_MUTE]))
        else $error("left mute did not take written value");

    right_mute_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_right_gain |=> right_mute_o == $past(reg_wdata_i[BIT_MUTE]))
        else $error("right mute did not take written value");

    headset_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        headset_det_en_i |=> headset_flag == $past(headset_sync))
        else $error("headset flag did not follow synced detector");

    mic_level_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_mic3_left |=> left_mix_level_o[1] == $past(reg_wdata_i[LO_LEVEL_MSB:0]))
        else $error("third mic right level not taken from low nibble");

    bias_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_second_line_left_in |=> left_weak_bias_o == $past(reg_wdata_i[BIT_WEAK_BIAS]))
        else $error("weak bias did not take written value");

    unmapped_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (reg_rd_i && (reg_addr_i < ADDR_DET_DRV || reg_addr_i > ADDR_FIRST_LINE_RIGHT_IN)) |=> reg_rdata_o == READ_UNMAPPED)
        else $error("unmapped read returned nonzero");

endmodule : adc_input_mix_pga_regs

// *** bench/fs_tick_model.sv ***
// Sample-rate pulse source standing in for the converter timing logic
`timescale 1ns/1ps
module fs_tick_model #(
    parameter int DIV = 16
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    output logic fs_tick_o
);
    int cnt;

    // Short period keeps soft-step walks brief in simulation
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= 0;
            fs_tick_o <= 1'b0;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            fs_tick_o <= (cnt == DIV - 1);
        end
    end
endmodule : fs_tick_model

// *** bench/test_adc_input_mix_pga_regs.sv ***
// Self-checking bench for the record front-end register bank
`timescale 1ns/1ps
module test_adc_input_mix_pga_regs;
    import adc_mix_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic button_press_i = 1'b0;
    logic headset_present_i = 1'b0;
    logic headset_det_en_i = 1'b0;
    step_mode_t right_step_mode_i = STEP_OFF_A;
    logic fs_tick;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o, ac_coupled_o, full_diff_out_o, pseudo_diff_out_o;
    logic left_mute_o, right_mute_o, left_adc_power_o, left_weak_bias_o;
    logic [6:0] left_gain_o, right_gain_o;
    logic [4:0][3:0] left_mix_level_o;
    logic [4:0] left_mix_connect_o;
    logic [1:0][3:0] right_mix_level_o;
    logic [1:0] right_mix_connect_o;
    logic [2:0] single_or_diff_select_o;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    fs_tick_model i_fs_tick_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fs_tick_o(fs_tick));

    adc_input_mix_pga_regs i_adc_input_mix_pga_regs (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .button_press_i, .headset_present_i,
        .headset_det_en_i, .fs_tick_i(fs_tick), .right_step_mode_i, .ac_coupled_o, .full_diff_out_o,
        .pseudo_diff_out_o, .left_mute_o, .right_mute_o, .left_gain_o, .right_gain_o,
        .left_mix_level_o, .left_mix_connect_o, .right_mix_level_o, .right_mix_connect_o,
        .single_or_diff_select_o, .left_adc_power_o, .left_weak_bias_o);

    task automatic wrap_up();
        $display("errors %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : idle

    // One-cycle strobe; extra idle so a following read sees the new value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        @(negedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        chk("rvalid", 8'h01, {7'h0, reg_rvalid_o});
        chk("rdata", exp, reg_rdata_o);
    endtask : rd

    task automatic test_reset_values();
        logic [7:0] rst [8] = '{8'h00, 8'h80, 8'h80, 8'hff, 8'hff, 8'h78, 8'h78, 8'h78};
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_DET_DRV + 8'(i), rst[i]);
        end
        chk("connect", 8'h00, {1'b0, right_mix_connect_o, left_mix_connect_o});
    endtask : test_reset_values

    // Never both D6 and D3, valid level codes except off code f in 8'h12 low nibble, reserved bits zero; read-only bits set to prove they drop
    task automatic test_routing();
        logic [7:0] a [8] = '{8'h0e, 8'h0e, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h20};
        logic [7:0] d [8] = '{8'hb8, 8'h40, 8'h08, 8'h8f, 8'hc6, 8'h04, 8'h88, 8'h5a};
        logic [7:0] e [8] = '{8'h88, 8'h40, 8'h08, 8'h8f, 8'hc6, 8'h04, 8'h88, 8'h00};
        for (int i = 0; i < 8; i++) begin
            wr(a[i], d[i]);
            rd(a[i], e[i]);
        end
        chk("drivers", 8'h02, {5'h0, ac_coupled_o, full_diff_out_o, pseudo_diff_out_o});
        chk("left_connect", 8'h1f, {3'h0, left_mix_connect_o});
        chk("right_connect", 8'h01, {6'h0, right_mix_connect_o});
        chk("right_levels", 8'hf8, right_mix_level_o);
        chk("level4", 8'h01, {4'h0, left_mix_level_o[4]});
        chk("modes", 8'h17, {3'h0, single_or_diff_select_o, left_adc_power_o, left_weak_bias_o});
        wr(8'h11, 8'hff);
        idle(2);
        chk("left_connect", 8'h1c, {3'h0, left_mix_connect_o});
    endtask : test_routing

    task automatic test_gain();
        wr(ADDR_LEFT_GAIN, 8'h7f);
        idle(2);
        chk("left_gain", 8'h77, {1'b0, left_gain_o});
        chk("left_mute", 8'h00, {7'h0, left_mute_o});
        rd(ADDR_LEFT_GAIN, 8'h7f);
        wr(ADDR_FIRST_LINE_LEFT_IN, 8'hc4);
        wr(ADDR_LEFT_GAIN, 8'h74);
        chk("stepping", 8'h01, {7'h0, left_gain_o !== 7'h74});
        idle(70);
        chk("left_gain", 8'h74, {1'b0, left_gain_o});
        right_step_mode_i = STEP_OFF_B;
        wr(ADDR_RIGHT_GAIN, 8'h05);
        idle(2);
        chk("right_gain", 8'h05, {right_mute_o, right_gain_o});
        // Three codes up: every-fs stepping ends by 48 cycles, every-two-fs not before 65
        right_step_mode_i = STEP_EVERY_2FS;
        wr(ADDR_RIGHT_GAIN, 8'h08);
        idle(47);
        chk("right_slow", 8'h01, {7'h0, right_gain_o !== 7'h08});
        idle(50);
        chk("right_gain", 8'h08, {right_mute_o, right_gain_o});
    endtask : test_gain

    task automatic test_flags();
        headset_det_en_i = 1'b1;
        button_press_i = 1'b1;
        idle(2);
        button_press_i = 1'b0;
        idle(5);
        rd(ADDR_DET_DRV, 8'h60);
        rd(ADDR_DET_DRV, 8'h40);
        headset_present_i = 1'b1;
        idle(5);
        rd(ADDR_DET_DRV, 8'h50);
        headset_det_en_i = 1'b0;
        idle(5);
        rd(ADDR_DET_DRV, 8'h40);
    endtask : test_flags

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        idle(2);
        reset_i = 1'b0;
        test_reset_values();
        test_routing();
        test_gain();
        test_flags();
        wrap_up();
    end
endmodule : test_adc_input_mix_pga_regs
